//--- design/pbt_params.svh
`ifndef PBT_PARAMS_SVH
`define PBT_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PBT_OFF_CTRL 6'h00
`define PBT_OFF_STAT 6'h04
`define PBT_OFF_SSTART 6'h08
`define PBT_OFF_SPITCH 6'h0C
`define PBT_OFF_DSTART 6'h10
`define PBT_OFF_DPITCH 6'h14
`define PBT_OFF_EXTENT 6'h18
`define PBT_OFF_BGCOL 6'h1C
`define PBT_OFF_FGCOL 6'h20
`define PBT_OFF_PWIDTH 6'h24
`define PBT_OFF_MSTART 6'h28
`define PBT_OFF_MPITCH 6'h2C
`define PBT_OFF_PMASK 6'h30

// ----------------------------------------
// field positions
// ----------------------------------------
`define PBT_CTRL_H 3
`define PBT_CTRL_V 4
`define PBT_CTRL_TRANS 5
`define PBT_CTRL_GO 7
`define PBT_STAT_BUSY 0
`define PBT_STAT_DONE 1

// ----------------------------------------
// reset values and fixed figures
// ----------------------------------------
`define PBT_PWIDTH_RST 6'h08
`define PBT_ALL_ONES 32'hFFFF_FFFF
`define PBT_FULL_PIX 6'h20
`define PBT_ONE_BIT 6'h01

`endif

//--- design/pbt_pkg.sv
package pbt_pkg;

   // engine sequencer states
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_SETUP = 5'h02,
      ST_RSRC  = 5'h04,
      ST_RMSK  = 5'h08,
      ST_WDST  = 5'h10
   } pbt_state_e;

   // transfer variants held in the control register
   typedef enum logic [2:0] {
      VAR_LIN_LIN = 3'h0,
      VAR_LIN_XY  = 3'h1,
      VAR_XY_LIN  = 3'h2,
      VAR_XY_XY   = 3'h3,
      VAR_EXP_LIN = 3'h4,
      VAR_EXP_XY  = 3'h5,
      VAR_MASKED  = 3'h6
   } pbt_var_e;

endpackage

//--- design/pbt_engine.sv
// Function
// (R1) Four copy variants: linear/XY source to linear/XY destination.
// (R2) Software sets packed linear pitch to width times pixel size.
// (R3) Default order: lowest address first, rows left to right, top down.
// (R4) XY variants adjust the corner automatically; linear and masked use software addresses.
// (R5) Horizontal direction bit 0 steps X up, 1 steps X down.
// (R6) Vertical direction bit 0 steps Y down the array, 1 steps up.
// (R7) Every pixel of a row finishes before the next row starts.
// (R8) XY transfers compute the corner start from start and extent.
// (R9) XY transfers write the chosen corner back into the start registers.
// (R10) Software loads corner addresses before non-default linear or masked copies.
// (R11) Expansion turns 1 into foreground and 0 into background colour.
// (R12) Expansion supports linear and XY destinations by separate variants.
// (R13) Expansion happens before transparency and plane masking.
// (R14) Plane mask is not applied when reading 1-bit source data.
// (R15) Expanding transfers read source pixels one bit wide.
// (R16) Software sets pixel width to the expanded destination width.
// (R17) Software sets packed 1-bit source pitch equal to row width.
// (R18) Masked copy is a linear-to-linear copy with a mask array.
// (R19) One mask bit per pixel decides if the destination pixel is written.
// (R20) Mask protection acts like transparency but ignores transparency mode.
// (R21) Mask bit, plane mask and transparency combine into bit-level protection.
// (R22) Mask start and pitch come from the mask start and pitch registers.
// (R23) Extent: width in low 16 bits, height in high 16, shared by both arrays.
// (R24) Start registers give each array's lowest address, linear or XY.
// (R25) Source and destination pitches are separate and may differ.
// (R26) Zero width or height ends the transfer with no memory write.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`include "pbt_params.svh"

module pbt_engine
   import pbt_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // register bus slave
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // local memory master
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [31:0] o_mem_addr,
   output logic [5:0] o_mem_size,
   output logic [31:0] o_mem_wdata,
   output logic [31:0] o_mem_wmask,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   // engine state
   output logic o_busy
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // byte-lane merge for partial bus writes
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // corner of one array: {register value, linear start address}
   function automatic logic [63:0] corner(input logic [31:0] st, input logic [31:0] pit,
                                          input logic [5:0] psz, input logic isxy, input logic adj,
                                          input logic [15:0] xo, input logic [15:0] yo);
      logic [15:0] cx;
      logic [15:0] cy;
      logic [31:0] lin;
      cx = st[15:0] + xo;
      cy = st[31:16] + yo;
      lin = st + 32'(yo) * pit + 32'(xo) * 32'(psz);
      if (isxy) begin
         corner = {cy, cx, 32'(cy) * pit + 32'(cx) * 32'(psz)};
      end else if (adj) begin
         corner = {lin, lin};
      end else begin
         corner = {st, st};
      end
   endfunction

   // address step, backwards when the direction bit is set
   function automatic logic [31:0] step(input logic [31:0] a, input logic [31:0] d, input logic neg);
      return neg ? a - d : a + d;
   endfunction

   // ----------------------------------------
   // state and registers
   // ----------------------------------------
   pbt_state_e st_q;
   logic avs_wait_q;
   logic [31:0] avs_rdata_q;
   logic [5:0] ctrl_q;
   logic done_q;
   logic busy_q;
   logic [31:0] sstart_q, spitch_q, dstart_q, dpitch_q, extent_q;
   logic [31:0] bg_q, fg_q, mstart_q, mpitch_q, pmask_q;
   logic [5:0] pixel_width_reg_q;
   logic [31:0] s_addr_q, s_row_q, d_addr_q, d_row_q, m_addr_q, m_row_q;
   logic [15:0] xcnt_q, ycnt_q;
   logic [31:0] pix_q;
   logic mbit_q;
   logic mem_req_q, mem_we_q;
   logic [31:0] mem_addr_q, mem_wdata_q, mem_wmask_q;
   logic [5:0] mem_size_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // first cycle of a request raises the answer; the next edge completes it
   wire bus_acc = (i_avs_read | i_avs_write) & avs_wait_q;
   wire wr_take = i_avs_write & ~avs_wait_q;
   // configuration is frozen while a transfer runs
   wire cfg_we = wr_take & ~busy_q;
   wire h_ctrl = i_avs_address == `PBT_OFF_CTRL;
   wire h_stat = i_avs_address == `PBT_OFF_STAT;
   wire h_ss = i_avs_address == `PBT_OFF_SSTART;
   wire h_sp = i_avs_address == `PBT_OFF_SPITCH;
   wire h_ds = i_avs_address == `PBT_OFF_DSTART;
   wire h_dp = i_avs_address == `PBT_OFF_DPITCH;
   wire h_ext = i_avs_address == `PBT_OFF_EXTENT;
   wire h_bg = i_avs_address == `PBT_OFF_BGCOL;
   wire h_fg = i_avs_address == `PBT_OFF_FGCOL;
   wire h_pw = i_avs_address == `PBT_OFF_PWIDTH;
   wire h_ms = i_avs_address == `PBT_OFF_MSTART;
   wire h_mp = i_avs_address == `PBT_OFF_MPITCH;
   wire h_pm = i_avs_address == `PBT_OFF_PMASK;
   wire go_w = cfg_we & h_ctrl & i_avs_byteenable[0] & i_avs_writedata[`PBT_CTRL_GO];
   wire [31:0] wd = i_avs_writedata;
   wire [3:0] be = i_avs_byteenable;
   // unmapped addresses read as zero
   wire [31:0] rd_mux = h_ctrl ? {26'h0, ctrl_q} :
                        h_stat ? {30'h0, done_q, busy_q} :
                        h_ss ? sstart_q : h_sp ? spitch_q :
                        h_ds ? dstart_q : h_dp ? dpitch_q :
                        h_ext ? extent_q : h_bg ? bg_q : h_fg ? fg_q :
                        h_pw ? {26'h0, pixel_width_reg_q} : h_ms ? mstart_q :
                        h_mp ? mpitch_q : h_pm ? pmask_q : 32'h0000_0000;

   // ----------------------------------------
   // variant decode and corner setup
   // ----------------------------------------
   // (R1) variant decode
   wire [2:0] var_w = ctrl_q[2:0];
   wire src_xy = var_w == VAR_XY_LIN || var_w == VAR_XY_XY;
   wire dst_xy = var_w == VAR_LIN_XY || var_w == VAR_XY_XY || var_w == VAR_EXP_XY;
   // (R12) expanding variants
   wire expand = var_w == VAR_EXP_LIN || var_w == VAR_EXP_XY;
   // (R18) masked is linear to linear
   wire masked = var_w == VAR_MASKED;
   // (R4) automatic corner only when an XY array is involved
   wire auto_w = src_xy | dst_xy;
   wire hdir = ctrl_q[`PBT_CTRL_H];
   wire vdir = ctrl_q[`PBT_CTRL_V];
   // (R23) extent halves
   wire [15:0] w_w = extent_q[15:0];
   wire [15:0] h_w = extent_q[31:16];
   wire [15:0] w1 = w_w - 16'h0001;
   wire [15:0] h1 = h_w - 16'h0001;
   // an unknown variant code also ends at once
   wire zero_ext = w_w == 16'h0000 || h_w == 16'h0000 || var_w == 3'h7;
   // (R15) expanding source pixels are one bit wide
   wire [5:0] spsz = expand ? `PBT_ONE_BIT : pixel_width_reg_q;
   wire [15:0] xo = hdir ? w1 : 16'h0000;
   wire [15:0] yo = vdir ? h1 : 16'h0000;
   // (R8) corner start from start register and extent
   wire [63:0] s_cor = corner(sstart_q, spitch_q, spsz, src_xy, auto_w, xo, yo);
   wire [63:0] d_cor = corner(dstart_q, dpitch_q, pixel_width_reg_q, dst_xy, auto_w, xo, yo);
   wire last_col = xcnt_q == w1;
   wire last_row = ycnt_q == h1;

   // ----------------------------------------
   // pixel data path
   // ----------------------------------------
   wire [31:0] pm_w = `PBT_ALL_ONES >> (`PBT_FULL_PIX - pixel_width_reg_q);
   // (R11) expansion to foreground or background
   wire [31:0] col_w = (expand ? (pix_q[0] ? fg_q : bg_q) : pix_q) & pm_w;
   // (R13) transparency looks at the expanded colour
   wire trans_w = ctrl_q[`PBT_CTRL_TRANS] && col_w == 32'h0000_0000;
   // (R20) mask bit protects whatever the transparency mode
   // (R21) bit-level protection from mask, plane mask and transparency
   wire [31:0] wmask_w = pm_w & ~pmask_q & {32{~trans_w & mbit_q}};
   wire acked = mem_req_q & i_mem_ack;

   // ----------------------------------------
   // register bus slave
   // ----------------------------------------
   // answer one cycle after the request appears
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         avs_wait_q <= 1'b1;
         avs_rdata_q <= 32'h0000_0000;
      end else begin
         avs_wait_q <= ~bus_acc;
         if (bus_acc) begin
            avs_rdata_q <= rd_mux;
         end
      end
   end

   // configuration registers; start registers also take the engine's corner
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ctrl_q <= 6'h00;
         sstart_q <= 32'h0000_0000;
         spitch_q <= 32'h0000_0000;
         dstart_q <= 32'h0000_0000;
         dpitch_q <= 32'h0000_0000;
         extent_q <= 32'h0000_0000;
         bg_q <= 32'h0000_0000;
         fg_q <= 32'h0000_0000;
         pixel_width_reg_q <= `PBT_PWIDTH_RST;
         mstart_q <= 32'h0000_0000;
         mpitch_q <= 32'h0000_0000;
         pmask_q <= 32'h0000_0000;
      end else if (st_q == ST_SETUP && !zero_ext && auto_w) begin
         // (R9) write the selected corner back
         sstart_q <= s_cor[63:32];
         dstart_q <= d_cor[63:32];
      end else if (cfg_we) begin
         if (h_ctrl && be[0]) ctrl_q <= wd[5:0];
         // (R24) start registers
         if (h_ss) sstart_q <= be_merge(sstart_q, wd, be);
         if (h_ds) dstart_q <= be_merge(dstart_q, wd, be);
         // (R25) independent pitches
         if (h_sp) spitch_q <= be_merge(spitch_q, wd, be);
         if (h_dp) dpitch_q <= be_merge(dpitch_q, wd, be);
         if (h_ext) extent_q <= be_merge(extent_q, wd, be);
         if (h_bg) bg_q <= be_merge(bg_q, wd, be);
         if (h_fg) fg_q <= be_merge(fg_q, wd, be);
         if (h_pw && be[0]) pixel_width_reg_q <= wd[5:0];
         // (R22) mask array registers
         if (h_ms) mstart_q <= be_merge(mstart_q, wd, be);
         if (h_mp) mpitch_q <= be_merge(mpitch_q, wd, be);
         if (h_pm) pmask_q <= be_merge(pmask_q, wd, be);
      end
   end

   // ----------------------------------------
   // sequencer and memory requests
   // ----------------------------------------
   // request is held until acknowledged, then dropped for one cycle
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q <= ST_IDLE;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_addr_q <= 32'h0000_0000;
         mem_size_q <= 6'h00;
         mem_wdata_q <= 32'h0000_0000;
         mem_wmask_q <= 32'h0000_0000;
         pix_q <= 32'h0000_0000;
         mbit_q <= 1'b1;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (go_w) begin
                  st_q <= ST_SETUP;
                  busy_q <= 1'b1;
                  done_q <= 1'b0;
               end
            end
            ST_SETUP: begin
               // (R26) empty array: finish with no write
               if (zero_ext) begin
                  st_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end else begin
                  st_q <= ST_RSRC;
               end
            end
            ST_RSRC: begin
               // (R14) source reads carry no plane mask
               if (!mem_req_q) begin
                  mem_req_q <= 1'b1;
                  mem_we_q <= 1'b0;
                  mem_addr_q <= s_addr_q;
                  mem_size_q <= spsz;
                  mem_wmask_q <= 32'h0000_0000;
               end else if (i_mem_ack) begin
                  mem_req_q <= 1'b0;
                  pix_q <= i_mem_rdata & (`PBT_ALL_ONES >> (`PBT_FULL_PIX - spsz));
                  mbit_q <= 1'b1;
                  st_q <= masked ? ST_RMSK : ST_WDST;
               end
            end
            ST_RMSK: begin
               // (R19) one mask bit per pixel
               if (!mem_req_q) begin
                  mem_req_q <= 1'b1;
                  mem_addr_q <= m_addr_q;
                  mem_size_q <= `PBT_ONE_BIT;
               end else if (i_mem_ack) begin
                  mem_req_q <= 1'b0;
                  mbit_q <= i_mem_rdata[0];
                  st_q <= ST_WDST;
               end
            end
            ST_WDST: begin
               if (!mem_req_q) begin
                  mem_req_q <= 1'b1;
                  mem_we_q <= 1'b1;
                  mem_addr_q <= d_addr_q;
                  mem_size_q <= pixel_width_reg_q;
                  mem_wdata_q <= col_w;
                  mem_wmask_q <= wmask_w;
               end else if (i_mem_ack) begin
                  mem_req_q <= 1'b0;
                  mem_we_q <= 1'b0;
                  mem_wmask_q <= 32'h0000_0000;
                  if (last_col && last_row) begin
                     st_q <= ST_IDLE;
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                  end else begin
                     st_q <= ST_RSRC;
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // array walk
   // ----------------------------------------
   // row bases are kept so a row change never accumulates column error
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         xcnt_q <= 16'h0000;
         ycnt_q <= 16'h0000;
         s_addr_q <= 32'h0000_0000;
         s_row_q <= 32'h0000_0000;
         d_addr_q <= 32'h0000_0000;
         d_row_q <= 32'h0000_0000;
         m_addr_q <= 32'h0000_0000;
         m_row_q <= 32'h0000_0000;
      end else if (st_q == ST_SETUP) begin
         // (R3) start at the chosen corner, lowest address by default
         xcnt_q <= 16'h0000;
         ycnt_q <= 16'h0000;
         s_addr_q <= s_cor[31:0];
         s_row_q <= s_cor[31:0];
         d_addr_q <= d_cor[31:0];
         d_row_q <= d_cor[31:0];
         m_addr_q <= mstart_q;
         m_row_q <= mstart_q;
      end else if (st_q == ST_WDST && acked) begin
         // (R7) finish the row before the next
         if (!last_col) begin
            xcnt_q <= xcnt_q + 16'h0001;
            // (R5) column step by direction
            s_addr_q <= step(s_addr_q, 32'(spsz), hdir);
            d_addr_q <= step(d_addr_q, 32'(pixel_width_reg_q), hdir);
            m_addr_q <= step(m_addr_q, 32'h0000_0001, hdir);
         end else begin
            xcnt_q <= 16'h0000;
            ycnt_q <= ycnt_q + 16'h0001;
            // (R6) row step by direction
            s_addr_q <= step(s_row_q, spitch_q, vdir);
            s_row_q <= step(s_row_q, spitch_q, vdir);
            d_addr_q <= step(d_row_q, dpitch_q, vdir);
            d_row_q <= step(d_row_q, dpitch_q, vdir);
            m_addr_q <= step(m_row_q, mpitch_q, vdir);
            m_row_q <= step(m_row_q, mpitch_q, vdir);
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_avs_readdata = avs_rdata_q;
   assign o_avs_waitrequest = avs_wait_q;
   assign o_mem_req = mem_req_q;
   assign o_mem_we = mem_we_q;
   assign o_mem_addr = mem_addr_q;
   assign o_mem_size = mem_size_q;
   assign o_mem_wdata = mem_wdata_q;
   assign o_mem_wmask = mem_wmask_q;
   assign o_busy = busy_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   empty_array_a: assert property ((st_q == ST_SETUP && zero_ext) |=> // (R26)
      (st_q == ST_IDLE && !mem_req_q && done_q)) else $error("empty array started memory traffic");
   default_start_a: assert property ((st_q == ST_SETUP && !zero_ext && !hdir && !vdir && !auto_w) // (R3)
      |=> s_addr_q == sstart_q && d_addr_q == dstart_q) else $error("default start not lowest address");
   corner_back_a: assert property ((st_q == ST_SETUP && !zero_ext && auto_w) // (R9)
      |=> sstart_q == $past(s_cor[63:32]) && dstart_q == $past(d_cor[63:32])) else $error("corner not stored");
   col_step_a: assert property ((st_q == ST_WDST && acked && !last_col) |=> // (R5)
      d_addr_q == (hdir ? $past(d_addr_q) - 32'(pixel_width_reg_q) : $past(d_addr_q) + 32'(pixel_width_reg_q)))
      else $error("column step wrong");
   row_step_a: assert property ((st_q == ST_WDST && acked && last_col && !last_row) |=> // (R6)
      d_addr_q == (vdir ? $past(d_row_q) - dpitch_q : $past(d_row_q) + dpitch_q)) else $error("row step wrong");
   row_first_a: assert property ((st_q == ST_WDST && acked && !last_col) |=> // (R7)
      $stable(ycnt_q) && xcnt_q == $past(xcnt_q) + 16'h0001) else $error("row left early");
   read_nomask_a: assert property ((mem_req_q && !mem_we_q) |-> mem_wmask_q == 32'h0000_0000) // (R14)
      else $error("read carries plane mask");
   exp_width_a: assert property ((st_q == ST_RSRC && mem_req_q && expand) |-> mem_size_q == `PBT_ONE_BIT) // (R15)
      else $error("expanded source not one bit");
   exp_color_a: assert property ((st_q == ST_WDST && mem_req_q && expand) |-> // (R11)
      mem_wdata_q == ((pix_q[0] ? fg_q : bg_q) & pm_w)) else $error("expanded colour wrong");
   mask_bits_a: assert property ((st_q == ST_WDST && mem_req_q) |-> // (R21)
      (mem_wmask_q & (~pm_w | pmask_q)) == 32'h0000_0000 && (mbit_q || mem_wmask_q == 32'h0000_0000))
      else $error("write mask exceeds protection");
   mask_read_a: assert property ((st_q == ST_RMSK && mem_req_q) |-> mem_size_q == `PBT_ONE_BIT // (R19)
      && mem_addr_q == m_addr_q) else $error("mask read wrong");

endmodule

//--- test/pbt_mem_model.sv
module pbt_mem_model (
   // clock
   input wire logic i_clk,
   // engine memory port
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [31:0] i_addr,
   input wire logic [5:0] i_size,
   input wire logic [31:0] i_wdata,
   input wire logic [31:0] i_wmask,
   output logic o_ack,
   output logic [31:0] o_rdata,
   // idle cycles before each answer
   input wire logic [3:0] i_lag
);
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------
   // bit-addressed local memory
   // ----------------------------------------
   logic mem [0:8191];
   int wait_q;

   initial begin
      o_ack = 1'b0;
      o_rdata = 32'h0000_0000;
      wait_q = 0;
      for (int i = 0; i < 8192; i++) mem[i] = 1'b0;
   end

   // one-cycle answer after i_lag cycles; data flips while idle so stale data never looks valid
   always @(posedge i_clk) begin
      if (i_req && !o_ack && wait_q >= int'(i_lag)) begin
         wait_q <= 0;
         o_ack <= 1'b1;
         for (int i = 0; i < 32; i++) begin
            o_rdata[i] <= (i < int'(i_size)) ? mem[(i_addr + i) % 8192] : 1'b0;
            if (i_we && i < int'(i_size) && i_wmask[i]) mem[(i_addr + i) % 8192] <= i_wdata[i];
         end
      end else begin
         if (i_req && !o_ack) begin
            wait_q <= wait_q + 1;
         end
         o_ack <= 1'b0;
         o_rdata <= ~o_rdata;
      end
   end
endmodule

//--- test/pbt_engine_tb.sv
`include "pbt_params.svh"

module pbt_engine_tb;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk, srst, rd, wr, wrq, mreq, mwe, mack, busy;
   logic [5:0] adr, msize;
   logic [31:0] wd, rdat, mask_start_reg, mwdat, mwmask, mrdat, q;
   logic [3:0] lag;
   logic [2:0] cur_var;
   logic [71:0] wq[$];
   int fail_count, cmp_count;

   pbt_engine dut (.i_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wrq),
      .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(mask_start_reg), .o_mem_size(msize), .o_mem_wdata(mwdat),
      .o_mem_wmask(mwmask), .i_mem_ack(mack), .i_mem_rdata(mrdat), .o_busy(busy));

   pbt_mem_model mem_u (.i_clk(clk), .i_req(mreq), .i_we(mwe), .i_addr(mask_start_reg), .i_size(msize),
      .i_wdata(mwdat), .i_wmask(mwmask), .o_ack(mack), .o_rdata(mrdat), .i_lag(lag));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic logic [7:0] spix(input int x, input int y);
      return 8'hA0 + 8'(16 * y + x);
   endfunction

   // request held until waitrequest is sampled low, then released; only the watchdog ends a hung wait
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
      end while (wrq !== 1'b0);
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wreg(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   // completed pixel writes in order; expanding reads must be one bit wide
   always @(posedge clk) begin
      if (mreq && mack && mwe) wq.push_back({mask_start_reg, mwdat[7:0], mwmask});
      if (mreq && mack && !mwe && cur_var inside {3'h4, 3'h5}) chk("expand read size", 72'h1, 72'(msize));
   end

   // ----------------------------------------
   // one transfer, two rows of w pixels
   // ----------------------------------------
   task automatic run(input logic [2:0] vr, input logic h, input logic v, input int w, input logic [31:0] pm);
      logic [31:0] r;
      logic [31:0] em;
      logic [7:0] p;
      bit sxy, dxy, ex, man, tr;
      int sp, dp, ss, sb, db, so, dof, x, y, n;
      sxy = vr inside {3'h2, 3'h3};
      dxy = vr inside {3'h1, 3'h3, 3'h5};
      ex = vr inside {3'h4, 3'h5};
      // transparency on the expand-to-XY run: a zero background must come out protected
      tr = vr == 3'h5;
      man = vr inside {3'h0, 3'h6};
      ss = ex ? 1 : 8;
      sp = sxy ? 64 : w * ss;
      dp = dxy ? 96 : 40;
      sb = sxy ? 1280 : (ex ? 512 : 1024);
      db = dxy ? 2896 : 2048;
      so = (h ? (w - 1) * ss : 0) + (v ? sp : 0);
      dof = (h ? (w - 1) * 8 : 0) + (v ? dp : 0);
      for (y = 0; y < 2; y++) begin
         for (x = 0; x < w; x++) begin
            p = spix(x, y);
            mem_u.mem[768 + y * 3 + x] = (x != 1);
            for (n = 0; n < ss; n++) mem_u.mem[sb + y * sp + x * ss + n] = ex ? ((x + y) % 2 == 1) : p[n];
         end
      end
      wq.delete();
      cur_var = vr;
      wreg(`PBT_OFF_SSTART, sxy ? 32'h0014_0000 : 32'(sb + (man ? so : 0)));
      wreg(`PBT_OFF_SPITCH, 32'(sp));
      wreg(`PBT_OFF_DSTART, dxy ? 32'h001E_0002 : 32'(db + (man ? dof : 0)));
      wreg(`PBT_OFF_DPITCH, 32'(dp));
      wreg(`PBT_OFF_EXTENT, {16'h0002, 16'(w)});
      wreg(`PBT_OFF_BGCOL, tr ? 32'h0000_0000 : 32'h0000_003C);
      wreg(`PBT_OFF_FGCOL, 32'h0000_00C3);
      wreg(`PBT_OFF_PWIDTH, 32'h0000_0008);
      wreg(`PBT_OFF_MSTART, 32'h0000_0300);
      wreg(`PBT_OFF_MPITCH, 32'h0000_0003);
      wreg(`PBT_OFF_PMASK, pm);
      wreg(`PBT_OFF_CTRL, 32'h0000_0080 | {26'h0, tr, v, h, vr});
      n = 0;
      r = 32'h0000_0000;
      while (r[1] !== 1'b1 && n < 500) begin
         bus(1'b0, `PBT_OFF_STAT, 32'h0000_0000, r);
         n++;
         if (n == 1) chk("busy pin running", 72'(w != 0), 72'(busy));
      end
      chk("done flag", 72'h1, 72'(r[1]));
      chk("busy pin idle", 72'h0, 72'(busy));
      chk("write count", 72'(2 * w), 72'(wq.size()));
      for (int k = 0; k < 2 * w; k++) begin
         y = v ? 1 - k / w : k / w;
         x = h ? w - 1 - k % w : k % w;
         p = ex ? ((x + y) % 2 == 1 ? 8'hC3 : (tr ? 8'h00 : 8'h3C)) : spix(x, y);
         em = (vr == 3'h6 && x == 1) || p == 8'h00 ? 32'h0000_0000 : 32'h0000_00FF & ~pm;
         if (wq.size() > 0) chk("pixel write", {32'(db + y * dp + x * 8), p, em},
            wq.pop_front());
      end
      if (w != 0) begin
         bus(1'b0, `PBT_OFF_SSTART, 32'h0000_0000, r);
         chk("source start", sxy ? {16'(20 + v), 16'(h ? w - 1 : 0)} : 32'(sb + so), r);
         bus(1'b0, `PBT_OFF_DSTART, 32'h0000_0000, r);
         chk("destination start", dxy ? {16'(30 + v), 16'(h ? w + 1 : 2)} : 32'(db + dof), r);
      end
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      srst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      adr = 6'h00;
      wd = 32'h0000_0000;
      lag = 4'h0;
      cur_var = 3'h0;
      fail_count = 0;
      cmp_count = 0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      bus(1'b0, `PBT_OFF_PWIDTH, 32'h0000_0000, q);
      chk("pixel width reset", 72'h8, 72'(q));
      bus(1'b1, `PBT_OFF_STAT, 32'hFFFF_FFFF, q);
      bus(1'b0, `PBT_OFF_STAT, 32'h0000_0000, q);
      chk("status read only", 72'h0, 72'(q));
      bus(1'b0, 6'h3C, 32'h0000_0000, q);
      chk("unmapped read", 72'h0, 72'(q));
      run(3'h0, 1'b0, 1'b0, 3, 32'h0000_0000);
      run(3'h1, 1'b1, 1'b0, 3, 32'h0000_0000);
      run(3'h2, 1'b0, 1'b1, 3, 32'h0000_0000);
      run(3'h3, 1'b1, 1'b1, 3, 32'h0000_0000);
      run(3'h0, 1'b1, 1'b1, 3, 32'h0000_0000);
      run(3'h4, 1'b0, 1'b0, 3, 32'h0000_0000);
      run(3'h5, 1'b1, 1'b1, 3, 32'h0000_000F);
      lag = 4'h3;
      run(3'h6, 1'b0, 1'b0, 3, 32'h0000_0000);
      run(3'h0, 1'b0, 1'b0, 0, 32'h0000_0000);
      tally_and_finish();
   end

   initial begin
      #300000;
      fail_count++;
      tally_and_finish();
   end
endmodule
